//--- inc/lcb_pkg.sv
// constants and carrier types of the led configuration bank
// Operation
// - chip enable bit 6 of register 0 gates all driving; resets to zero
// - bit 5 of register 1 picks logarithmic (1) or linear (0) curve
// - bit 4 of register 1 enables automatic power saving; resets to one
// - bit 3 of register 1 lets the pointer advance after each access
// - bit 2 of register 1 enables pwm dithering; resets to one
// - bit 1 of register 1 picks 35 mA (1) or 25.5 mA (0) range
// - bit 0 of register 1 turns every led output off; resets to zero
// - bit n of register 2 puts rgb module n under shared group control
// - register 3 is the group brightness, linear in code, resets to FFh
// - registers 4 to 6 are group colour fractions, each resetting to zero
package lcb_pkg;

    localparam int NUM_MODULES = 8;
    localparam int NUM_CHANNELS = 3;

    // register offsets
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_OPTION = 8'h01;
    localparam logic [7:0] ADDR_GROUP_SEL = 8'h02;
    localparam logic [7:0] ADDR_BRIGHT = 8'h03;
    localparam logic [7:0] ADDR_COLOUR0 = 8'h04;
    localparam logic [7:0] ADDR_COLOUR1 = 8'h05;
    localparam logic [7:0] ADDR_COLOUR2 = 8'h06;

    // field positions
    localparam int BIT_CHIP_EN = 6;
    localparam int BIT_LOG_CURVE = 5;
    localparam int BIT_POWER_SAVE = 4;
    localparam int BIT_AUTO_INCR = 3;
    localparam int BIT_DITHER = 2;
    localparam int BIT_HIGH_RANGE = 1;
    localparam int BIT_ALL_OFF = 0;

    // values after reset
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h3c;
    localparam logic [7:0] RST_GROUP_SEL = 8'h00;
    localparam logic [7:0] RST_BRIGHT = 8'hff;
    localparam logic [7:0] RST_COLOUR = 8'h00;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // the seven configuration registers
    typedef struct packed {
        logic [7:0]       device_enable_cfg;
        logic [7:0]       global_option_cfg;
        logic [7:0]       module_group_select;
        logic [7:0]       group_brightness;
        logic [2:0][7:0]  group_colour;
    } lcb_regs_s;

    // colour and brightness of one rgb module
    typedef struct packed {
        logic [2:0][7:0]  colour;
        logic [7:0]       brightness;
    } lcb_pixel_s;

    // whole state of the bank
    typedef struct packed {
        lcb_regs_s        regs;
        logic [7:0]       ptr;
        logic [7:0]       rdata;
        logic             rvalid;
        logic             drive_enable;
        logic             log_curve;
        logic             power_save;
        logic             dither;
        logic             high_range;
        logic             all_outputs_off;
        lcb_pixel_s [7:0] pixel;
    } lcb_state_s;

endpackage

//--- rtl/lcb_config_bank.sv
// configuration register bank of the multi-channel led driver
`timescale 1ns/100ps
module lcb_config_bank
    import lcb_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_addr_load,
    input  wire logic [7:0]       i_addr,
    input  wire logic             i_wr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_rd,
    input  wire lcb_pixel_s [7:0] i_own_pixel,
    output logic [7:0]            o_ptr,
    output logic [7:0]            o_rdata,
    output logic                  o_rvalid,
    output logic                  o_drive_enable,
    output logic                  o_log_curve,
    output logic                  o_power_save,
    output logic                  o_auto_incr,
    output logic                  o_dither,
    output logic                  o_high_range,
    output logic                  o_all_outputs_off,
    output logic [7:0]            o_module_group_select,
    output lcb_pixel_s [7:0]      o_pixel
);

    lcb_state_s q;
    lcb_state_s next_q;

    // register read mux; offsets outside the bank answer a fixed value
    function automatic logic [7:0] read_reg(input lcb_regs_s r,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = UNMAPPED_READ;
        case (a)
            ADDR_ENABLE:    v = r.device_enable_cfg;
            ADDR_OPTION:    v = r.global_option_cfg;
            ADDR_GROUP_SEL: v = r.module_group_select;
            ADDR_BRIGHT:    v = r.group_brightness;
            ADDR_COLOUR0:   v = r.group_colour[0];
            ADDR_COLOUR1:   v = r.group_colour[1];
            ADDR_COLOUR2:   v = r.group_colour[2];
            default:        v = UNMAPPED_READ;
        endcase
        return v;
    endfunction

    // next state: pointer, register writes, read data, derived controls
    always_comb begin
        logic access;
        logic active;
        access = (i_wr || i_rd) && !i_addr_load;
        active = 1'b0;
        next_q = q;
        next_q.rvalid = 1'b0;
        // a new address from the bus engine beats a data access
        if (i_addr_load) begin
            next_q.ptr = i_addr;
        end else if (access && q.regs.global_option_cfg[BIT_AUTO_INCR]) begin
            next_q.ptr = q.ptr + 8'h01;
        end
        // whole bytes stored, reserved bits included
        if (i_wr && !i_addr_load) begin
            case (q.ptr)
                ADDR_ENABLE: begin
                    next_q.regs.device_enable_cfg = i_wdata;
                end
                ADDR_OPTION: begin
                    next_q.regs.global_option_cfg = i_wdata;
                end
                ADDR_GROUP_SEL: next_q.regs.module_group_select = i_wdata;
                ADDR_BRIGHT:    next_q.regs.group_brightness = i_wdata;
                ADDR_COLOUR0:   next_q.regs.group_colour[0] = i_wdata;
                ADDR_COLOUR1:   next_q.regs.group_colour[1] = i_wdata;
                ADDR_COLOUR2:   next_q.regs.group_colour[2] = i_wdata;
                default:        next_q.regs = q.regs;
            endcase
        end else if (i_rd && !i_addr_load) begin
            // write wins when both strobes arrive together
            next_q.rdata = read_reg(q.regs, q.ptr);
            next_q.rvalid = 1'b1;
        end
        // controls follow the register in the same edge
        active = next_q.regs.device_enable_cfg[BIT_CHIP_EN]
                 && !next_q.regs.global_option_cfg[BIT_ALL_OFF];
        next_q.drive_enable = active;
        next_q.log_curve = next_q.regs.global_option_cfg[BIT_LOG_CURVE];
        next_q.power_save =
            next_q.regs.global_option_cfg[BIT_POWER_SAVE];
        next_q.dither = next_q.regs.global_option_cfg[BIT_DITHER];
        next_q.high_range =
            next_q.regs.global_option_cfg[BIT_HIGH_RANGE];
        next_q.all_outputs_off =
            next_q.regs.global_option_cfg[BIT_ALL_OFF];
        // per module source select; dark while disabled or shut down
        for (int m = 0; m < NUM_MODULES; m++) begin
            if (!active) begin
                next_q.pixel[m] = '0;
            end else if (next_q.regs.module_group_select[m]) begin
                next_q.pixel[m].colour = next_q.regs.group_colour;
                next_q.pixel[m].brightness =
                    next_q.regs.group_brightness;
            end else begin
                next_q.pixel[m] = i_own_pixel[m];
            end
        end
    end

    // single state register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q.regs.device_enable_cfg <= RST_ENABLE;
            q.regs.global_option_cfg <= RST_OPTION;
            q.regs.module_group_select <= RST_GROUP_SEL;
            q.regs.group_brightness <= RST_BRIGHT;
            q.regs.group_colour <= {NUM_CHANNELS{RST_COLOUR}};
            q.ptr <= RST_PTR;
            q.rdata <= UNMAPPED_READ;
            q.rvalid <= 1'b0;
            q.drive_enable <= 1'b0;
            q.log_curve <= RST_OPTION[BIT_LOG_CURVE];
            q.power_save <= RST_OPTION[BIT_POWER_SAVE];
            q.dither <= RST_OPTION[BIT_DITHER];
            q.high_range <= RST_OPTION[BIT_HIGH_RANGE];
            q.all_outputs_off <= RST_OPTION[BIT_ALL_OFF];
            q.pixel <= '0;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from the state flops
    assign o_ptr = q.ptr;
    assign o_rdata = q.rdata;
    assign o_rvalid = q.rvalid;
    assign o_drive_enable = q.drive_enable;
    assign o_log_curve = q.log_curve;
    assign o_power_save = q.power_save;
    assign o_auto_incr = q.regs.global_option_cfg[BIT_AUTO_INCR];
    assign o_dither = q.dither;
    assign o_high_range = q.high_range;
    assign o_all_outputs_off = q.all_outputs_off;
    assign o_module_group_select = q.regs.module_group_select;
    assign o_pixel = q.pixel;

    // checks on the bank behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_wr_at(logic [7:0] a);
        i_wr && !i_addr_load && (q.ptr == a);
    endsequence

    sequence s_rd_at(logic [7:0] a);
        i_rd && !i_wr && !i_addr_load && (q.ptr == a);
    endsequence

    a_chip_disable_dark: assert property (
        s_wr_at(ADDR_ENABLE) ##0 !i_wdata[BIT_CHIP_EN]
        |=> !o_drive_enable && (o_pixel[0].brightness == 8'h00))
        else $error("drive still enabled after chip enable cleared");

    a_curve_follows_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_log_curve == $past(i_wdata[BIT_LOG_CURVE]))
        else $error("curve select does not follow written bit");

    a_power_save_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_power_save == $past(i_wdata[BIT_POWER_SAVE]))
        else $error("power saving does not follow written bit");

    a_ptr_advance: assert property (
        (i_wr || i_rd) && !i_addr_load
        |=> o_ptr == ($past(o_auto_incr) ? $past(o_ptr) + 8'h01
                                         : $past(o_ptr)))
        else $error("pointer step wrong for auto increment setting");

    a_dither_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_dither == $past(i_wdata[BIT_DITHER]))
        else $error("dither enable does not follow written bit");

    a_range_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_high_range == $past(i_wdata[BIT_HIGH_RANGE]))
        else $error("current range does not follow written bit");

    a_global_off_dark: assert property (
        o_all_outputs_off
        |-> !o_drive_enable && (o_pixel[7].brightness == 8'h00))
        else $error("outputs alive while global off set");

    a_own_source: assert property (
        o_drive_enable && !o_module_group_select[1]
        |-> o_pixel[1] == $past(i_own_pixel[1]))
        else $error("independent module not fed from own values");

    a_group_source: assert property (
        o_drive_enable && o_module_group_select[2]
        |-> (o_pixel[2].colour == q.regs.group_colour)
            && (o_pixel[2].brightness == q.regs.group_brightness))
        else $error("group module not fed from group registers");

    a_bright_readback: assert property (
        s_rd_at(ADDR_BRIGHT)
        |=> o_rvalid && (o_rdata == $past(q.regs.group_brightness)))
        else $error("group brightness read back wrong");

    a_colour_store: assert property (
        s_wr_at(ADDR_COLOUR1)
        |=> q.regs.group_colour[1] == $past(i_wdata))
        else $error("second group colour not stored");

    a_reserved_kept: assert property (
        s_wr_at(ADDR_ENABLE)
        |=> q.regs.device_enable_cfg == $past(i_wdata))
        else $error("reserved bits not kept as written");

    // pointer load and the auto-increment control itself
    a_ptr_load: assert property (
        i_addr_load
        |=> o_ptr == $past(i_addr))
        else $error("pointer not loaded from the bus address");

    a_incr_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_auto_incr == $past(i_wdata[BIT_AUTO_INCR]))
        else $error("auto increment does not follow written bit");

    // enable and shutdown paths
    a_off_bit: assert property (
        s_wr_at(ADDR_OPTION)
        |=> o_all_outputs_off == $past(i_wdata[BIT_ALL_OFF]))
        else $error("global off does not follow written bit");

    a_chip_enable_on: assert property (
        s_wr_at(ADDR_ENABLE) ##0 i_wdata[BIT_CHIP_EN]
        ##0 !q.regs.global_option_cfg[BIT_ALL_OFF]
        |=> o_drive_enable)
        else $error("drive not enabled after chip enable set");

    a_disabled_all_dark: assert property (
        !o_drive_enable
        |-> o_pixel == '0)
        else $error("a module is lit while driving is disabled");

    // every byte of the bank lands where the pointer says
    a_group_sel_store: assert property (
        s_wr_at(ADDR_GROUP_SEL)
        |=> o_module_group_select == $past(i_wdata))
        else $error("module group select not stored");

    a_bright_store: assert property (
        s_wr_at(ADDR_BRIGHT)
        |=> q.regs.group_brightness == $past(i_wdata))
        else $error("group brightness not stored");

    a_colour_first: assert property (
        s_wr_at(ADDR_COLOUR0)
        |=> q.regs.group_colour[0] == $past(i_wdata))
        else $error("first group colour not stored");

    a_colour_third: assert property (
        s_wr_at(ADDR_COLOUR2)
        |=> q.regs.group_colour[2] == $past(i_wdata))
        else $error("third group colour not stored");

    a_option_kept: assert property (
        s_wr_at(ADDR_OPTION)
        |=> q.regs.global_option_cfg == $past(i_wdata))
        else $error("option byte not kept as written");

    // controls only move on a write to the option byte
    a_curve_steady: assert property (
        !(i_wr && !i_addr_load && (q.ptr == ADDR_OPTION))
        |=> $stable(o_log_curve) && $stable(o_dither))
        else $error("curve or dither changed without an option write");

    a_range_steady: assert property (
        !(i_wr && !i_addr_load && (q.ptr == ADDR_OPTION))
        |=> $stable(o_high_range) && $stable(o_power_save))
        else $error("range or power saving changed without a write");

    // read strobe: valid only after a taken read
    a_read_pulse: assert property (
        !(i_rd && !i_wr && !i_addr_load)
        |=> !o_rvalid)
        else $error("read data marked valid without a read");

    // offsets past the bank: reads give a fixed byte, writes are dropped
    a_unmapped_read: assert property (
        i_rd && !i_wr && !i_addr_load && (q.ptr > ADDR_COLOUR2)
        |=> o_rvalid && (o_rdata == UNMAPPED_READ))
        else $error("read outside the bank gave a wrong byte");

    a_unmapped_write: assert property (
        i_wr && !i_addr_load && (q.ptr > ADDR_COLOUR2)
        |=> $stable(q.regs))
        else $error("write outside the bank changed a register");

    // load, one idle cycle, then a read of the loaded offset
    sequence s_load_then_read(logic [7:0] a);
        i_addr_load && (i_addr == a)
        ##1 !i_addr_load && !i_wr && !i_rd
        ##1 i_rd && !i_wr && !i_addr_load;
    endsequence

    a_select_readback: assert property (
        s_load_then_read(ADDR_GROUP_SEL)
        |=> o_rvalid && (o_rdata == o_module_group_select))
        else $error("module group select read back wrong");

    a_enable_readback: assert property (
        s_load_then_read(ADDR_ENABLE)
        |=> o_rvalid && (o_rdata == q.regs.device_enable_cfg))
        else $error("enable byte read back wrong");

endmodule // lcb_config_bank

//--- tb/lcb_config_bank_bench.sv
// self-checking bench of the led configuration bank
`timescale 1ns/100ps
module lcb_config_bank_bench;
    import lcb_pkg::*;
    logic             i_clk, i_rstn, al, wr, rd, rv, de, lc, ps, ai, di, hr, ao;
    logic [7:0]       ad, wd, o_ptr, o_rdata, gs, ptr;
    logic [7:0]       m [0:6];
    logic [31:0]      seed;
    lcb_pixel_s [7:0] own, pix;
    int               miscompares, compares;

    lcb_host_model i_host (.i_clk(i_clk), .o_addr_load(al), .o_addr(ad),
        .o_wr(wr), .o_wdata(wd), .o_rd(rd));
    lcb_config_bank i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr_load(al),
        .i_addr(ad), .i_wr(wr), .i_wdata(wd), .i_rd(rd), .i_own_pixel(own),
        .o_ptr(o_ptr), .o_rdata(o_rdata), .o_rvalid(rv), .o_drive_enable(de),
        .o_log_curve(lc), .o_power_save(ps), .o_auto_incr(ai), .o_dither(di),
        .o_high_range(hr), .o_all_outputs_off(ao),
        .o_module_group_select(gs), .o_pixel(pix));

    // free-running 100 mhz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // reset held four cycles; model back to its reset image
    task automatic rst();
        i_rstn = 1'b0;
        m = '{8'h00, 8'h3c, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
        ptr = 8'h00;
        repeat (4) @(posedge i_clk);
        #1 i_rstn = 1'b1;
    endtask

    task automatic seek(input logic [7:0] a);
        i_host.op(2'd0, a);
        ptr = a;
        chk(o_ptr, a);
    endtask

    // pointer moves by the auto-increment value seen before the access
    task automatic put(input logic [7:0] d);
        logic inc;
        inc = m[1][3];
        i_host.op(2'd1, d);
        if (ptr < 8'h07) m[ptr] = d;
        if (inc) ptr = ptr + 8'h01;
        chk(o_ptr, ptr);
    endtask

    task automatic get();
        logic [7:0] e;
        e = (ptr < 8'h07) ? m[ptr] : 8'h00;
        i_host.op(2'd2, 8'h00);
        chk(rv, 1'b1);
        chk(o_rdata, e);
        if (m[1][3]) ptr = ptr + 8'h01;
        chk(o_ptr, ptr);
    endtask

    task automatic chk_out();
        logic on;
        on = m[0][6] & ~m[1][0];
        chk(de, on);
        chk(lc, m[1][5]);
        chk(ps, m[1][4]);
        chk(ai, m[1][3]);
        chk(di, m[1][2]);
        chk(hr, m[1][1]);
        chk(ao, m[1][0]);
        chk(gs, m[2]);
        for (int k = 0; k < 8; k++)
            chk(pix[k], !on ? 32'h0 : m[2][k] ? {m[6], m[5], m[4], m[3]}
                : own[k]);
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #20000;
        miscompares++;
        stop_test();
    end

    initial begin
        seed = 32'h0001_1757;
        own = '0;
        rst();
        chk_out();
        seek(8'h00);
        repeat (8) get();
        $display("test reset values done");
        for (int r = 0; r < 5; r++) begin
            for (int k = 0; k < 8; k++) own[k] = rnd();
            seek(8'h00);
            put(8'(rnd()) & 8'h40 | (r > 1 ? 8'h40 : 8'h00));
            put(8'(rnd()) & 8'h3f);
            repeat (5) put(8'(rnd()));
            chk_out();
            seek(8'h07);
            put(8'(rnd()));
            seek(8'h00);
            repeat (8) get();
            seek(8'h02);
            get();
            chk_out();
            $display("test random round %0d done", r);
        end
        rst();
        chk_out();
        $display("test second reset done");
        stop_test();
    end
endmodule // lcb_config_bank_bench

//--- tb/lcb_host_model.sv
// host stand-in that drives the register access port of the bank
`timescale 1ns/100ps
module lcb_host_model (
    input  wire logic  i_clk,
    output logic       o_addr_load,
    output logic [7:0] o_addr,
    output logic       o_wr,
    output logic [7:0] o_wdata,
    output logic       o_rd
);
    // idle at time zero; unused data lines show no stale value
    initial begin
        o_addr_load = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h5a;
        o_wdata = 8'ha5;
    end

    // one request held for exactly one taking edge, then released
    task automatic op(input logic [1:0] kind, input logic [7:0] val);
        @(posedge i_clk);
        #1;
        o_addr_load = (kind == 2'd0);
        o_wr = (kind == 2'd1);
        o_rd = (kind == 2'd2);
        o_addr = val;
        o_wdata = val;
        @(posedge i_clk);
        #1;
        o_addr_load = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~val; // inverse, so a late sample is caught
        o_wdata = ~val;
    endtask
endmodule // lcb_host_model
